// ===== hw/fcg_pkg.sv
// Purpose: shared constants for the flash command guard and protection block
// Assumes: 8-bit registers, each on one aligned 32-bit word of an AHB-Lite slave
// Notes: offsets are byte addresses on haddr[15:0]
package fcg_pkg;

  // register byte addresses
  localparam logic [15:0] ADDR_DIV  = 16'h1820;
  localparam logic [15:0] ADDR_PROT = 16'h1824;
  localparam logic [15:0] ADDR_CFG  = 16'h1828;
  localparam logic [15:0] ADDR_STAT = 16'h182C;
  localparam logic [15:0] ADDR_CMD  = 16'h1830;

  // backdoor key window in the flash array
  localparam logic [15:0] KEY_FIRST = 16'hFFB0;
  localparam logic [15:0] KEY_LAST  = 16'hFFB7;

  // command codes
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE  = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE  = 8'h40;
  localparam logic [7:0] CMD_MASS  = 8'h41;

  // protection register fields
  localparam int          PROT_OPEN_BIT = 7;
  localparam int          PROT_DIS_BIT  = 6;
  localparam int          PROT_FPS_MSB  = 5;
  localparam int          PROT_FPS_LSB  = 3;
  localparam logic [7:0]  PROT_IMPL     = 8'hF8;

  // configuration register fields
  localparam int          CFG_KEY_WRITE_ENABLE_BIT = 5;
  localparam logic [7:0]  CFG_IMPL       = 8'h20;
  localparam logic [7:0]  CFG_RST        = 8'h00;

  // status register fields
  localparam int          STAT_CBEF_BIT  = 7;
  localparam int          STAT_IDLE_BIT  = 6;
  localparam int          STAT_DIVOK_BIT = 5;
  localparam int          STAT_ERR_BIT   = 4;

  localparam logic [7:0]  DIV_RST = 8'h00;
  localparam logic [7:0]  CMD_RST = 8'h00;

  // command sequence states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ADDR = 2'b01,
    SEQ_CMD  = 2'b10,
    SEQ_BUSY = 2'b11
  } fcg_seq_e;

endpackage

// ===== hw/fcg_flash_guard.sv
// Purpose: flash command sequence checker, block protection and key steering
// Assumes: array write port decoded by the system on sys_clk; one word per register
// Notes: zero-wait-state AHB-Lite slave, reads sampled in the address phase
`timescale 1ns/1ps
`default_nettype none

// Operation
// - array write before any clock divider write raises access error
// - array write while buffer empty flag is clear raises access error
// - second array write before launch raises access error
// - second command code write before launch raises access error
// - after array write, control write other than command code is an error
// - only five command codes accepted; any other code raises access error
// - after command code, any control access except launch write is an error
// - stop entry during running program or erase aborts it with error
// - secured debug writes of program or page erase codes raise error
// - writing zero to buffer empty flag mid-command is an access error
// - mass erase refused while any block is protected
// - protection register loaded from stored protection byte during reset
// - protection register always readable; user writes leave it unchanged
// - debug controller writes protection register at its fixed address
// - protection bits 0 to 2 read as zero
// - protection bit 7 clear blocks program and erase of all flash
// - protection bit 6 clear protects top block; set protects none
// - size field bits 5 to 3 select protected top block size
// - key bit steers key window writes to key strobe or command start
// - key bit set makes flash array reads invalid
module fcg_flash_guard
  import fcg_pkg::*;
#(
  parameter logic [15:0]   FLASH_TOP     = 16'hFFFF,
  parameter logic [127:0]  PROT_SIZE_TBL = {16'h8000, 16'h8000, 16'h4000, 16'h2000,
                                            16'h1000, 16'h0800, 16'h0400, 16'h0200}
)(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        hdebug,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        arrWrValid,
  input  wire logic [15:0] arrWrAddr,
  input  wire logic [7:0]  arrWrData,
  input  wire logic        secured,
  input  wire logic        stopEntry,
  input  wire logic        cmdDone,
  input  wire logic [7:0]  storedProtByte,
  output logic             cmdLaunch,
  output logic      [7:0]  launchCode,
  output logic      [15:0] launchAddr,
  output logic      [7:0]  launchData,
  output logic             cmdAbort,
  output logic             keyWrStrobe,
  output logic      [2:0]  keyIndex,
  output logic      [7:0]  keyData,
  output logic             readInvalid,
  output logic             accessError
);

  for (genvar i = 0; i < 8; i++)
  begin : g_chk
    if (PROT_SIZE_TBL[i*16 +: 16] == 16'h0000)
    begin : g_bad
      $error("protected size entry must be nonzero");
    end
  end

  fcg_seq_e    seq_r, seqNxt;
  logic        dpValid_r, dpWrite_r, dpDebug_r;
  logic [15:0] dpAddr_r;
  logic [7:0]  div_r, cfg_r, prot_r, code_r;
  logic        divSet_r, accErr_r;
  logic [15:0] pendAddr_r;
  logic [7:0]  pendData_r;
  logic        errSet, launchGo, abortGo, keyGo;
  logic [7:0]  codeNxt;
  logic        busWr, rdCtrl, inKey, key_write_enable, arrCmdWr;
  logic [7:0]  wrData, rdMux;
  logic        statWr, idleLike;

  function automatic logic isCtrl(input logic [15:0] a);
    return (a == ADDR_DIV) || (a == ADDR_PROT) || (a == ADDR_CFG) ||
           (a == ADDR_STAT) || (a == ADDR_CMD);
  endfunction

  // top block base computed in 17 bits so a full-size entry cannot wrap
  function automatic logic inTopBlock(input logic [15:0] a, input logic [2:0] fps);
    logic [16:0] base;
    base = {1'b0, FLASH_TOP} + 17'h00001 - {1'b0, PROT_SIZE_TBL[fps*16 +: 16]};
    return {1'b0, a} >= base;
  endfunction

  function automatic logic isProtected(input logic [15:0] a, input logic [7:0] p);
    return !p[PROT_OPEN_BIT] ||
           (!p[PROT_DIS_BIT] && inTopBlock(a, p[PROT_FPS_MSB:PROT_FPS_LSB]));
  endfunction

  assign key_write_enable   = cfg_r[CFG_KEY_WRITE_ENABLE_BIT];
  assign inKey    = (arrWrAddr >= KEY_FIRST) && (arrWrAddr <= KEY_LAST);
  assign arrCmdWr = arrWrValid && !(key_write_enable && inKey);
  assign busWr    = dpValid_r && dpWrite_r;
  assign wrData   = hwdata[7:0];
  assign statWr   = busWr && (dpAddr_r == ADDR_STAT);
  assign rdCtrl   = hsel && htrans[1] && hready && !hwrite && isCtrl(haddr[15:0]);
  assign idleLike = (seq_r == SEQ_IDLE) || (seq_r == SEQ_BUSY);

  // bus address phase capture; single-word transfers, hsize not decoded
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      dpValid_r <= 1'b0;
      dpWrite_r <= 1'b0;
      dpDebug_r <= 1'b0;
      dpAddr_r  <= 16'h0000;
    end
    else
    begin
      dpValid_r <= hsel && htrans[1] && hready;
      dpWrite_r <= hwrite;
      dpDebug_r <= hdebug;
      dpAddr_r  <= haddr[15:0];
    end
  end

  always_comb
  begin
    unique case (haddr[15:0])
      ADDR_DIV:  rdMux = div_r;
      ADDR_PROT: rdMux = prot_r;
      ADDR_CFG:  rdMux = cfg_r;
      ADDR_STAT: rdMux = {seq_r != SEQ_BUSY, seq_r == SEQ_IDLE, divSet_r, accErr_r, 4'h0};
      ADDR_CMD:  rdMux = code_r;
      default:   rdMux = 8'h00;
    endcase
  end

  // read data fixed in the address phase so the slave never waits
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hrdata    <= (hsel && htrans[1] && hready && !hwrite) ? {24'h000000, rdMux} : 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_comb
  begin
    seqNxt   = seq_r;
    codeNxt  = code_r;
    errSet   = 1'b0;
    launchGo = 1'b0;
    abortGo  = 1'b0;
    keyGo    = arrWrValid && key_write_enable && inKey;
    if (arrCmdWr)
    begin
      if (!divSet_r)
        errSet = 1'b1;
      else if (seq_r == SEQ_BUSY)
        errSet = 1'b1;
      else if (seq_r != SEQ_IDLE)
        errSet = 1'b1;
      else if (busWr || rdCtrl)
        errSet = 1'b1;
      else
        seqNxt = SEQ_ADDR;
    end
    else
    begin
      if (rdCtrl && (seq_r == SEQ_CMD))
        errSet = 1'b1;
      if (busWr && isCtrl(dpAddr_r))
      begin
        unique case (seq_r)
          SEQ_ADDR:
          begin
            if (dpAddr_r == ADDR_CMD)
            begin
              if ((wrData != CMD_BLANK) && (wrData != CMD_BYTE) && (wrData != CMD_BURST) &&
                  (wrData != CMD_PAGE) && (wrData != CMD_MASS))
                errSet = 1'b1;
              else if (dpDebug_r && secured &&
                       ((wrData == CMD_BYTE) || (wrData == CMD_BURST) || (wrData == CMD_PAGE)))
                errSet = 1'b1;
              else if ((wrData == CMD_MASS) &&
                       (!prot_r[PROT_OPEN_BIT] || !prot_r[PROT_DIS_BIT]))
                errSet = 1'b1;
              else if ((wrData != CMD_BLANK) && (wrData != CMD_MASS) &&
                       isProtected(pendAddr_r, prot_r))
                errSet = 1'b1;
              else
              begin
                seqNxt  = SEQ_CMD;
                codeNxt = wrData;
              end
            end
            else if ((dpAddr_r == ADDR_STAT) && !wrData[STAT_CBEF_BIT])
              errSet = 1'b1;
            else
              errSet = 1'b1;
          end
          SEQ_CMD:
          begin
            if ((dpAddr_r == ADDR_STAT) && wrData[STAT_CBEF_BIT] && !accErr_r)
            begin
              seqNxt   = SEQ_BUSY;
              launchGo = 1'b1;
            end
            else if ((dpAddr_r == ADDR_STAT) && !wrData[STAT_CBEF_BIT])
              errSet = 1'b1;
            else
              errSet = 1'b1;
          end
          default:
          begin
            // a code with no address before it is out of sequence
            if (dpAddr_r == ADDR_CMD)
              errSet = 1'b1;
          end
        endcase
      end
    end
    if ((seq_r == SEQ_BUSY) && cmdDone)
      seqNxt = SEQ_IDLE;
    if ((seq_r == SEQ_BUSY) && stopEntry && (code_r != CMD_BLANK))
    begin
      abortGo = 1'b1;
      errSet  = 1'b1;
      seqNxt  = SEQ_IDLE;
    end
    if (errSet && ((seq_r == SEQ_ADDR) || (seq_r == SEQ_CMD)))
      seqNxt = SEQ_IDLE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      seq_r      <= SEQ_IDLE;
      code_r     <= CMD_RST;
      pendAddr_r <= 16'h0000;
      pendData_r <= 8'h00;
    end
    else
    begin
      seq_r  <= seqNxt;
      code_r <= codeNxt;
      if (arrCmdWr && (seq_r == SEQ_IDLE))
      begin
        pendAddr_r <= arrWrAddr;
        pendData_r <= arrWrData;
      end
    end
  end

  // sticky error, set wins over clear
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      accErr_r <= 1'b0;
    else
      accErr_r <= errSet || (accErr_r && !(statWr && wrData[STAT_ERR_BIT]));
  end

  // divider and config only change outside a half-built command
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      div_r    <= DIV_RST;
      divSet_r <= 1'b0;
      cfg_r    <= CFG_RST;
    end
    else if (busWr && idleLike)
    begin
      if (dpAddr_r == ADDR_DIV)
      begin
        div_r    <= wrData;
        divSet_r <= 1'b1;
      end
      if (dpAddr_r == ADDR_CFG)
        cfg_r <= wrData & CFG_IMPL;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      prot_r <= storedProtByte & PROT_IMPL;
    else if (busWr && dpDebug_r && idleLike && (dpAddr_r == ADDR_PROT))
      prot_r <= wrData & PROT_IMPL;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      cmdLaunch   <= 1'b0;
      launchCode  <= CMD_RST;
      launchAddr  <= 16'h0000;
      launchData  <= 8'h00;
      cmdAbort    <= 1'b0;
      keyWrStrobe <= 1'b0;
      keyIndex    <= 3'b000;
      keyData     <= 8'h00;
      readInvalid <= 1'b0;
      accessError <= 1'b0;
    end
    else
    begin
      cmdLaunch   <= launchGo;
      cmdAbort    <= abortGo;
      keyWrStrobe <= keyGo;
      readInvalid <= key_write_enable;
      accessError <= errSet || (accErr_r && !(statWr && wrData[STAT_ERR_BIT]));
      if (launchGo)
      begin
        launchCode <= code_r;
        launchAddr <= pendAddr_r;
        launchData <= pendData_r;
      end
      if (keyGo)
      begin
        keyIndex <= arrWrAddr[2:0];
        keyData  <= arrWrData;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  div_before_arr_a: assert property (arrCmdWr && !divSet_r |=> accErr_r)
    else $error("array write before divider did not flag error");
  busy_arr_err_a: assert property (arrCmdWr && seq_r == SEQ_BUSY |=> accErr_r)
    else $error("array write while busy did not flag error");
  second_arr_a: assert property (seq_r == SEQ_ADDR && arrCmdWr |=> accErr_r && seq_r == SEQ_IDLE)
    else $error("second array write not rejected");
  bad_code_a: assert property (seq_r == SEQ_ADDR && busWr && dpAddr_r == ADDR_CMD &&
    wrData != CMD_BLANK && wrData != CMD_BYTE && wrData != CMD_BURST &&
    wrData != CMD_PAGE && wrData != CMD_MASS && !arrCmdWr |=> accErr_r ##1 !cmdLaunch)
    else $error("illegal code not rejected");
  user_prot_a: assert property (busWr && !dpDebug_r && dpAddr_r == ADDR_PROT |=> $stable(prot_r))
    else $error("user write changed protection");
  prot_rsv_a: assert property (prot_r[2:0] == 3'b000)
    else $error("protection reserved bits not zero");
  stop_abort_a: assert property (seq_r == SEQ_BUSY && stopEntry && code_r != CMD_BLANK
    |=> cmdAbort && accErr_r && seq_r == SEQ_IDLE)
    else $error("stop entry did not abort command");
  launch_gate_a: assert property (cmdLaunch |-> $past(!accErr_r) && $past(seq_r) == SEQ_CMD)
    else $error("launch with error pending");
  mass_prot_a: assert property (cmdLaunch && launchCode == CMD_MASS
    |-> prot_r[PROT_OPEN_BIT] && prot_r[PROT_DIS_BIT])
    else $error("mass erase launched while protected");
  key_steer_a: assert property (arrWrValid && key_write_enable && inKey
    |=> keyWrStrobe ##1 (seq_r != SEQ_CMD || !cmdLaunch))
    else $error("key write not steered");
  read_inv_a: assert property ($rose(key_write_enable) |=> readInvalid [*2])
    else $error("reads not marked invalid");

  launch_c: cover property (seq_r == SEQ_CMD ##1 cmdLaunch);
  abort_c: cover property (cmdAbort);
  key_c: cover property (keyWrStrobe);
  dbg_prot_c: cover property (busWr && dpDebug_r && dpAddr_r == ADDR_PROT);

endmodule // fcg_flash_guard

`default_nettype wire

// ===== testbench/fcg_far_model.sv
// Purpose: far side of the guard: array write source and command engine
// Assumes: bench calls put() for each array write
// Notes: engine ends a command 3 cycles after launch unless held
`timescale 1ns/1ps
`default_nettype none
module fcg_far_model (
  input  wire logic        sys_clk,
  input  wire logic        cmdLaunch,
  input  wire logic        holdDone,
  output logic             arrWrValid,
  output logic      [15:0] arrWrAddr,
  output logic      [7:0]  arrWrData,
  output logic             cmdDone
);
  int busyCnt = 0;
  initial
  begin
    arrWrValid = 1'b0;
    arrWrAddr  = 16'h0000;
    arrWrData  = 8'h00;
    cmdDone    = 1'b0;
  end
  // lines show inverted values between writes, never a stale copy
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    arrWrValid <= 1'b1;
    arrWrAddr  <= a;
    arrWrData  <= d;
    @(posedge sys_clk);
    arrWrValid <= 1'b0;
    arrWrAddr  <= ~a;
    arrWrData  <= ~d;
  endtask
  // holdDone stalls the engine for the slow-answer cases
  always @(posedge sys_clk)
  begin
    cmdDone <= 1'b0;
    if (cmdLaunch === 1'b1)
      busyCnt <= 3;
    else if (busyCnt != 0 && !holdDone)
    begin
      busyCnt <= busyCnt - 1;
      cmdDone <= (busyCnt == 1);
    end
  end
endmodule // fcg_far_model
`default_nettype wire

// ===== testbench/flash_cmd_guard_protect_tb_top.sv
// Purpose: self-checking bench for the flash command guard
// Assumes: zero-wait AHB-Lite slave, hready tied to hreadyout
// Notes: errors are cleared by writing 1 to status bit 4
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_guard_protect_tb_top;
  import fcg_pkg::*;
  logic sys_clk = 0, resetn = 0, hsel = 0, hwrite = 0, hdebug = 0;
  logic secured = 0, stopEntry = 0, holdDone = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic [7:0]  launchCode, launchData, keyData, arrWrData, q;
  logic [15:0] launchAddr, arrWrAddr;
  logic [2:0]  keyIndex;
  logic cmdLaunch, cmdAbort, keyWrStrobe, readInvalid, accessError, arrWrValid, cmdDone;
  int bad_count = 0, total_checks = 0, cycles = 0, launches = 0, aborts = 0, keys = 0, n0;
  logic [7:0] codes [5] = '{CMD_BLANK, CMD_BYTE, CMD_BURST, CMD_PAGE, CMD_MASS};

  fcg_flash_guard dut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hdebug(hdebug), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .arrWrValid(arrWrValid), .arrWrAddr(arrWrAddr), .arrWrData(arrWrData),
    .secured(secured), .stopEntry(stopEntry), .cmdDone(cmdDone), .storedProtByte(8'hFF),
    .cmdLaunch(cmdLaunch), .launchCode(launchCode), .launchAddr(launchAddr),
    .launchData(launchData), .cmdAbort(cmdAbort), .keyWrStrobe(keyWrStrobe),
    .keyIndex(keyIndex), .keyData(keyData), .readInvalid(readInvalid),
    .accessError(accessError));
  fcg_far_model far (.sys_clk(sys_clk), .cmdLaunch(cmdLaunch), .holdDone(holdDone),
    .arrWrValid(arrWrValid), .arrWrAddr(arrWrAddr), .arrWrData(arrWrData),
    .cmdDone(cmdDone));

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    launches += (cmdLaunch === 1'b1);
    aborts += (cmdAbort === 1'b1);
    keys += (keyWrStrobe === 1'b1);
    if (cycles == 5000)
    begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // address phase held until hready, then data phase until hready
  task automatic bus(input logic [15:0] a, input logic wr, input logic [7:0] d,
                     input logic dbg);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {16'h0000, a};
    hwrite <= wr;
    hdebug <= dbg;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1)
      @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1)
      @(posedge sys_clk);
    q = hrdata[7:0];
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic dbg);
    bus(a, 1'b1, d, dbg);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 8'h00, 1'b0);
    chk({8'h00, q}, {8'h00, exp});
    chk({15'h0000, hresp}, 16'h0000);
  endtask
  // an expected error is checked, then cleared and checked gone
  task automatic errChk(input logic exp);
    repeat (2) @(posedge sys_clk);
    chk({15'h0000, accessError}, {15'h0000, exp});
    if (exp)
    begin
      wr(ADDR_STAT, 8'h10, 1'b0);
      repeat (2) @(posedge sys_clk);
      chk({15'h0000, accessError}, 16'h0000);
    end
  endtask
  task automatic cmdSeq(input logic [15:0] a, input logic [7:0] c, input logic dbg,
                        input logic ok);
    n0 = launches;
    far.put(a, 8'h5A);
    wr(ADDR_CMD, c, dbg);
    wr(ADDR_STAT, 8'h80, dbg);
    repeat (3) @(posedge sys_clk);
    chk(16'(launches - n0), {15'h0000, ok});
    if (ok)
      chk(launchAddr ^ {launchCode, launchData}, a ^ {c, 8'h5A});
    repeat (6) @(posedge sys_clk);
    errChk(!ok);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(ADDR_PROT, 8'hF8);
    far.put(16'h1000, 8'h11);
    errChk(1'b1);
    wr(ADDR_DIV, 8'h13, 1'b0);
    wr(ADDR_PROT, 8'h00, 1'b0);
    rd(ADDR_PROT, 8'hF8);
    for (int i = 0; i < 5; i++)
      cmdSeq(16'h1000, codes[i], 1'b0, 1'b1);
    cmdSeq(16'h1000, 8'h11, 1'b0, 1'b0);
    far.put(16'h1000, 8'h01);
    far.put(16'h1001, 8'h02);
    errChk(1'b1);
    far.put(16'h1000, 8'h01);
    wr(ADDR_CMD, CMD_BYTE, 1'b0);
    wr(ADDR_CMD, CMD_BYTE, 1'b0);
    errChk(1'b1);
    far.put(16'h1000, 8'h01);
    wr(ADDR_DIV, 8'h13, 1'b0);
    errChk(1'b1);
    far.put(16'h1000, 8'h01);
    wr(ADDR_STAT, 8'h00, 1'b0);
    errChk(1'b1);
    far.put(16'h1000, 8'h01);
    wr(ADDR_CMD, CMD_BYTE, 1'b0);
    bus(ADDR_STAT, 1'b0, 8'h00, 1'b0);
    errChk(1'b1);
    secured <= 1'b1;
    cmdSeq(16'h1000, CMD_BURST, 1'b1, 1'b0);
    cmdSeq(16'h1000, CMD_MASS, 1'b1, 1'b1);
    secured <= 1'b0;
    wr(ADDR_CMD, 8'h11, 1'b0);
    cmdSeq(16'h1000, CMD_BYTE, 1'b0, 1'b0);
    wr(ADDR_PROT, 8'h40, 1'b1);
    rd(ADDR_PROT, 8'h40);
    cmdSeq(16'h1000, CMD_BYTE, 1'b0, 1'b0);
    wr(ADDR_PROT, 8'h80, 1'b1);
    cmdSeq(16'h1000, CMD_MASS, 1'b0, 1'b0);
    cmdSeq(16'hFE00, CMD_PAGE, 1'b0, 1'b0);
    cmdSeq(16'hFDFF, CMD_PAGE, 1'b0, 1'b1);
    wr(ADDR_PROT, 8'h88, 1'b1);
    cmdSeq(16'hFC00, CMD_BYTE, 1'b0, 1'b0);
    wr(ADDR_PROT, 8'hC0, 1'b1);
    cmdSeq(16'hFF00, CMD_PAGE, 1'b0, 1'b1);
    holdDone <= 1'b1;
    cmdSeq(16'h1000, CMD_BYTE, 1'b0, 1'b1);
    far.put(16'h1001, 8'h03);
    errChk(1'b1);
    holdDone <= 1'b0;
    repeat (8) @(posedge sys_clk);
    holdDone <= 1'b1;
    cmdSeq(16'h1000, CMD_BYTE, 1'b0, 1'b1);
    n0 = aborts;
    stopEntry <= 1'b1;
    @(posedge sys_clk);
    stopEntry <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(16'(aborts - n0), 16'h0001);
    errChk(1'b1);
    holdDone <= 1'b0;
    wr(ADDR_CFG, 8'h20, 1'b0);
    repeat (2) @(posedge sys_clk);
    chk({15'h0000, readInvalid}, 16'h0001);
    far.put(16'hFFB3, 8'h77);
    repeat (2) @(posedge sys_clk);
    chk({5'h00, keyIndex, keyData}, 16'h0377);
    chk(16'(keys), 16'h0001);
    errChk(1'b0);
    wr(ADDR_CFG, 8'h00, 1'b0);
    cmdSeq(16'hFFB3, CMD_BYTE, 1'b0, 1'b1);
    close_out();
  end
endmodule // flash_cmd_guard_protect_tb_top
`default_nettype wire
